// *** hw/branch_cond_pkg.sv ***
// Constants for the branch condition evaluator
// What this block does
// - Field 0000 never satisfied; field 1000 always satisfied, whatever the flags.
// - Single-flag tests: 0111/1111 carry, 0110/1110 zero, 0101/1101 sign, 0100/1100 overflow.
// - Field 1001 true when sign xor overflow is 0; field 0001 when it is 1.
// - Field 1010 true when zero or (sign xor overflow) is 0; 0010 when 1.
// - Field 0011 true when carry or zero; field 1011 when both are clear.
// - Flag register at 252 holds carry, zero, sign, overflow, decimal-adjust, half-carry.
package branch_cond_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int COND_W = 4;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 8'hfc;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FLAGS_MASK = 8'hfc;
  // Flag bit positions
  localparam int CARRY_BIT = 7;
  localparam int ZERO_BIT = 6;
  localparam int SIGN_BIT = 5;
  localparam int WRAP_BIT = 4;
  localparam int DEC_BIT = 3;
  localparam int HALF_BIT = 2;
  localparam int INVERT_BIT = 3;
  // Base tests selected by field bits 2..0
  localparam logic [2:0] SEL_NEVER = 3'h0;
  localparam logic [2:0] SEL_SIGNED_BELOW = 3'h1;
  localparam logic [2:0] SEL_SIGNED_NOT_ABOVE = 3'h2;
  localparam logic [2:0] SEL_UNSIGNED_NOT_ABOVE = 3'h3;
  localparam logic [2:0] SEL_WRAP_SET = 3'h4;
  localparam logic [2:0] SEL_SIGN_SET = 3'h5;
  localparam logic [2:0] SEL_ZERO_SET = 3'h6;
  localparam logic [2:0] SEL_CARRY_SET = 3'h7;
endpackage : branch_cond_pkg

// *** hw/branch_condition_evaluator.sv ***
// Condition evaluator with its flag register
`timescale 1ns/1ns
module branch_condition_evaluator #(
  parameter int ADDR_W = branch_cond_pkg::ADDR_W, // Register address width
  parameter int DATA_W = branch_cond_pkg::DATA_W, // Flag register width
  parameter int COND_W = branch_cond_pkg::COND_W // Condition field width
) (
  input wire logic mclk_i, // 20 MHz core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [ADDR_W-1:0] addr_i, // Register address
  input wire logic [DATA_W-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [DATA_W-1:0] flags_in_i, // Flags from ALU
  input wire logic flags_load_i, // ALU flag update
  input wire logic [COND_W-1:0] cond_i, // Condition field
  input wire logic eval_i, // Evaluate request
  output logic [DATA_W-1:0] rdata_o, // Read data
  output logic [DATA_W-1:0] flags_o, // Flag register
  output logic taken_o, // Branch taken
  output logic taken_vld_o // Decision valid pulse
);

  // Flag bits that the condition tests look at
  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic wrap;
  } test_flags_s;

  // Flag register state
  logic [DATA_W-1:0] flags_r;
  logic [DATA_W-1:0] flags_nxt;
  // Read port state
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  // Decision state
  logic taken_r;
  logic taken_nxt;
  logic vld_r;
  logic vld_nxt;
  // Decoded strobes, flag view and field parts
  logic wr_hit;
  logic rd_hit;
  test_flags_s cur_flags;
  logic [branch_cond_pkg::INVERT_BIT-1:0] test_sel;
  logic test_invert;
  logic base_result;
  logic decided;

  // Flag layout is fixed at eight bits
  if (DATA_W != branch_cond_pkg::DATA_W) begin : g_bad_data_w
    $error("flag register width must be eight");
  end
  // Condition field is fixed at four bits
  if (COND_W != branch_cond_pkg::COND_W) begin : g_bad_cond_w
    $error("condition field width must be four");
  end
  // Address must reach the flag register
  if (ADDR_W < branch_cond_pkg::ADDR_W) begin : g_bad_addr_w
    $error("address too narrow for the flag register");
  end
  // Carry position inside the register
  if (branch_cond_pkg::CARRY_BIT >= DATA_W) begin : g_bad_carry
    $error("carry position outside the register");
  end
  // Zero position inside the register
  if (branch_cond_pkg::ZERO_BIT >= DATA_W) begin : g_bad_zero
    $error("zero position outside the register");
  end
  // Sign position inside the register
  if (branch_cond_pkg::SIGN_BIT >= DATA_W) begin : g_bad_sign
    $error("sign position outside the register");
  end
  // Wrap position inside the register
  if (branch_cond_pkg::WRAP_BIT >= DATA_W) begin : g_bad_wrap
    $error("wrap position outside the register");
  end
  // Decimal-adjust position inside the register
  if (branch_cond_pkg::DEC_BIT >= DATA_W) begin : g_bad_dec
    $error("decimal-adjust position outside the register");
  end
  // Half-carry position inside the register
  if (branch_cond_pkg::HALF_BIT >= DATA_W) begin : g_bad_half
    $error("half-carry position outside the register");
  end
  // Invert bit must be the top field bit
  if (branch_cond_pkg::INVERT_BIT != COND_W - 1) begin : g_bad_invert
    $error("invert bit must be the top field bit");
  end
  // Reset value may not set bits that hold no flag
  if ((branch_cond_pkg::FLAGS_RESET & ~branch_cond_pkg::FLAGS_MASK) != 8'h00) begin : g_bad_reset
    $error("reset value sets an unused bit");
  end

  // True when an address selects the flag register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a == ADDR_W'(branch_cond_pkg::FLAGS_ADDR));
    return hit;
  endfunction : addr_hit

  // Clear the bits that hold no flag
  function automatic logic [DATA_W-1:0] keep_flags(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] kept;
    kept = d & DATA_W'(branch_cond_pkg::FLAGS_MASK);
    return kept;
  endfunction : keep_flags

  // Pick the four tested flags out of a flag byte
  function automatic test_flags_s unpack_flags(input logic [DATA_W-1:0] f);
    test_flags_s t;
    t.carry = f[branch_cond_pkg::CARRY_BIT];
    t.zero = f[branch_cond_pkg::ZERO_BIT];
    t.sign = f[branch_cond_pkg::SIGN_BIT];
    t.wrap = f[branch_cond_pkg::WRAP_BIT];
    return t;
  endfunction : unpack_flags

  // Never test: false whatever the flags
  function automatic logic never_of(input test_flags_s t);
    logic r;
    r = 1'b0 & t.carry;
    return r;
  endfunction : never_of

  // Carry set test
  function automatic logic carry_set_of(input test_flags_s t);
    logic r;
    r = t.carry;
    return r;
  endfunction : carry_set_of

  // Zero set test
  function automatic logic zero_set_of(input test_flags_s t);
    logic r;
    r = t.zero;
    return r;
  endfunction : zero_set_of

  // Sign set test
  function automatic logic sign_set_of(input test_flags_s t);
    logic r;
    r = t.sign;
    return r;
  endfunction : sign_set_of

  // Wrap set test
  function automatic logic wrap_set_of(input test_flags_s t);
    logic r;
    r = t.wrap;
    return r;
  endfunction : wrap_set_of

  // Signed below: sign and wrap disagree
  function automatic logic signed_below_of(input test_flags_s t);
    logic r;
    r = t.sign ^ t.wrap;
    return r;
  endfunction : signed_below_of

  // Signed not above: zero, or signed below
  function automatic logic signed_not_above_of(input test_flags_s t);
    logic r;
    r = t.zero | signed_below_of(t);
    return r;
  endfunction : signed_not_above_of

  // Unsigned not above: carry or zero
  function automatic logic unsigned_not_above_of(input test_flags_s t);
    logic r;
    r = t.carry | t.zero;
    return r;
  endfunction : unsigned_not_above_of

  // Base test chosen by the low field bits
  function automatic logic base_test(input logic [branch_cond_pkg::INVERT_BIT-1:0] sel, input test_flags_s t);
    logic r;
    r = 1'b0;
    case (sel)
      branch_cond_pkg::SEL_NEVER: begin
        r = never_of(t);
      end
      branch_cond_pkg::SEL_SIGNED_BELOW: begin
        r = signed_below_of(t);
      end
      branch_cond_pkg::SEL_SIGNED_NOT_ABOVE: begin
        r = signed_not_above_of(t);
      end
      branch_cond_pkg::SEL_UNSIGNED_NOT_ABOVE: begin
        r = unsigned_not_above_of(t);
      end
      branch_cond_pkg::SEL_WRAP_SET: begin
        r = wrap_set_of(t);
      end
      branch_cond_pkg::SEL_SIGN_SET: begin
        r = sign_set_of(t);
      end
      branch_cond_pkg::SEL_ZERO_SET: begin
        r = zero_set_of(t);
      end
      branch_cond_pkg::SEL_CARRY_SET: begin
        r = carry_set_of(t);
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction : base_test

  // Top field bit turns each base test into its opposite
  function automatic logic apply_invert(input logic base, input logic inv);
    logic r;
    r = base ^ inv;
    return r;
  endfunction : apply_invert

  // Address decode for the two strobes
  always_comb begin
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    if (wr_i) begin
      wr_hit = addr_hit(addr_i);
    end
    if (rd_i) begin
      rd_hit = addr_hit(addr_i);
    end
  end

  // Flag view, field split and decision value
  always_comb begin
    cur_flags = unpack_flags(flags_r);
    test_sel = cond_i[branch_cond_pkg::INVERT_BIT-1:0];
    test_invert = cond_i[branch_cond_pkg::INVERT_BIT];
    base_result = base_test(test_sel, cur_flags);
    decided = apply_invert(base_result, test_invert);
  end

  // Flag register next value; a software write beats an ALU load
  always_comb begin
    flags_nxt = flags_r;
    if (flags_load_i) begin
      flags_nxt = keep_flags(flags_in_i);
    end
    if (wr_hit) begin
      flags_nxt = keep_flags(wdata_i);
    end
  end

  // Flag register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_r <= branch_cond_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Read data next value; unmapped reads return zero
  always_comb begin
    rdata_nxt = '0;
    if (rd_hit) begin
      rdata_nxt = flags_r;
    end
  end

  // Read data register, valid one cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Decision next values, one answer per request
  always_comb begin
    vld_nxt = eval_i;
    taken_nxt = 1'b0;
    if (eval_i) begin
      taken_nxt = decided;
    end
  end

  // Decision registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      taken_r <= 1'b0;
      vld_r <= 1'b0;
    end else begin
      taken_r <= taken_nxt;
      vld_r <= vld_nxt;
    end
  end

  // Register port outputs
  assign rdata_o = rdata_r;
  assign flags_o = flags_r;

  // Decision outputs
  assign taken_o = taken_r;
  assign taken_vld_o = vld_r;
endmodule : branch_condition_evaluator

// *** testbench/bce_chk_properties.sv ***
// Checker for decision and flag read timing
`timescale 1ns/1ns
module bce_chk (
  input wire logic mclk_i, // Core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [7:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [7:0] flags_in_i, // Flags from ALU
  input wire logic flags_load_i, // ALU flag update
  input wire logic [3:0] cond_i, // Condition field
  input wire logic eval_i, // Evaluate request
  input wire logic [7:0] rdata_o, // Read data
  input wire logic [7:0] flags_o, // Flag register
  input wire logic taken_o, // Branch taken
  input wire logic taken_vld_o // Decision valid pulse
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Reference decision, bit 3 inverting the base test
  function automatic logic dec(logic [3:0] c, logic [7:0] f);
    logic [7:0] b = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
    return b[c[2:0]] ^ c[3];
  endfunction : dec
  // Requests seen by the block
  sequence eval_req;
    eval_i;
  endsequence
  sequence flag_rd_req;
    rd_i && addr_i == 8'hfc;
  endsequence
  sequence flag_wr_req;
    wr_i && addr_i == 8'hfc;
  endsequence
  AST_DECIDE: assert property (
    eval_req |=> taken_vld_o && taken_o == dec($past(cond_i), $past(flags_o))) else $error("bad decision");
  AST_IDLE: assert property (!eval_i |=> !taken_vld_o && !taken_o) else $error("stray decision");
  AST_READ: assert property (
    flag_rd_req |=> rdata_o == $past(flags_o)) else $error("bad flag read");
  AST_READ_ZERO: assert property (
    !(rd_i && addr_i == 8'hfc) |=> rdata_o == 8'h00) else $error("stray read data");
  AST_WRITE: assert property (
    flag_wr_req |=> flags_o == ($past(wdata_i) & 8'hfc)) else $error("bad flag write");
  AST_LOAD: assert property (
    flags_load_i && !(wr_i && addr_i == 8'hfc) |=> flags_o == ($past(flags_in_i) & 8'hfc)) else $error("bad flag load");
  AST_SPARE: assert property (
    flags_o[1:0] == 2'h0) else $error("unused flag bits set");
endmodule : bce_chk
bind branch_condition_evaluator bce_chk bce_chk_inst(.*);

// *** testbench/alu_model.sv ***
// ALU model: one-cycle flag updates
`timescale 1ns/1ns
module alu_model(input wire logic mclk_i, output logic [7:0] flags_in_o = '0, output logic flags_load_o = '0);
  task automatic put(logic [7:0] f);
    @(posedge mclk_i);
    flags_in_o <= f;
    flags_load_o <= 1'b1;
    @(posedge mclk_i);
    flags_in_o <= ~f; // Released data scrambled
    flags_load_o <= 1'b0;
  endtask : put
endmodule : alu_model

// *** testbench/tb_top.sv ***
// Testbench: flag register and all condition codes
`timescale 1ns/1ns
module tb_top;
  logic mclk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, eval_i = 0, fld, taken_o, taken_vld_o;
  logic [7:0] addr_i = '0, wdata_i = '0, fin, rdata_o, flags_o;
  logic [3:0] cond_i = '0;
  int miscompares, total_checks, cyc;
  logic [7:0] fv [6] = '{8'h00, 8'hff, 8'h80, 8'h20, 8'h50, 8'h30};
  logic [15:0] msk [6] = '{16'hff00, 16'h03fc, 16'h7788, 16'hd926, 16'ha15e, 16'hcf30};
  branch_condition_evaluator branch_condition_evaluator_inst(.*, .flags_in_i(fin), .flags_load_i(fld));
  alu_model alu_model_inst(.mclk_i, .flags_in_o(fin), .flags_load_o(fld));
  initial forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (++cyc == 1000) begin miscompares++; end_sim(); end
  task automatic chk_data(string n, logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end
  endtask : chk_data
  task automatic chk_taken(string n, logic [1:0] e, g);
    total_checks++;
    if (g !== e) begin miscompares++; $display("[ERR] %s exp %b got %b", n, e, g); end
  endtask : chk_taken
  task automatic bus(logic w, logic [7:0] a, d);
    @(posedge mclk_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
    @(posedge mclk_i);
    {wr_i, rd_i} <= '0;
    #1 if (!w) chk_data("rdata", d, rdata_o);
  endtask : bus
  task automatic ev(logic [3:0] c, logic e);
    @(posedge mclk_i);
    {cond_i, eval_i} <= {c, 1'b1};
    @(posedge mclk_i);
    eval_i <= 1'b0;
    #1 chk_taken("taken", {1'b1, e}, {taken_vld_o, taken_o});
  endtask : ev
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    bus(0, 8'hfc, 8'h00);
    for (int i = 0; i < 6; i++) begin
      if (i % 2) bus(1, 8'hfc, fv[i]);
      else alu_model_inst.put(fv[i]);
      bus(0, 8'hfc, fv[i] & 8'hfc);
      for (int c = 0; c < 16; c++) ev(4'(c), msk[i][c]);
    end
    fork
      alu_model_inst.put(8'hc0);
      bus(1, 8'hfc, 8'h40);
    join
    chk_data("flags", 8'h40, flags_o);
    bus(0, 8'hfc, 8'h40);
    bus(1, 8'hfc, 8'h30);
    chk_data("flags", 8'h30, flags_o);
    bus(1, 8'hfd, 8'h00);
    bus(0, 8'hfd, 8'h00);
    bus(0, 8'hfc, 8'h30);
    end_sim();
  end
endmodule : tb_top
